/* File: mis_pkg.sv */
// constants and types for the interrupt source block
package mis_pkg;
	localparam logic [7:0]  ADDR_ENABLE    = 8'hA8;
	localparam logic [7:0]  ADDR_PRIORITY  = 8'hB8;
	localparam logic [15:0] ADDR_EXT0_SRC  = 16'h7F00;
	localparam logic [15:0] ADDR_EXT0_MASK = 16'h7F01;
	localparam logic [15:0] ADDR_EXT1_SRC  = 16'h7F02;
	localparam logic [15:0] ADDR_EXT1_MASK = 16'h7F03;
	localparam int NUM_IRQ    = 6;
	localparam int BIT_GLOBAL = 7;
	localparam int IDX_EXT0   = 0;
	localparam int IDX_TMR0   = 1;
	localparam int IDX_EXT1   = 2;
	localparam int IDX_TMR1   = 3;
	localparam int IDX_SERIAL = 4;
	localparam int IDX_WAKE   = 5;
	localparam logic [5:0][7:0] VECTORS = {8'h2B, 8'h23, 8'h1B, 8'h13, 8'h0B, 8'h03};
	localparam logic [7:0] REG_RESET     = 8'h00;
	localparam logic [7:0] ENABLE_USED   = 8'hBF;
	localparam logic [7:0] PRIORITY_USED = 8'h3F;
	localparam logic [7:0] EXT0_USED     = 8'h0F;
	localparam logic [7:0] EXT1_RD_CLEAR = 8'h7D;
	localparam int E0_WAKE3  = 0;
	localparam int E0_WAKE2  = 1;
	localparam int E0_WAKE4  = 2;
	localparam int E0_RXMSB  = 3;
	localparam int E1_WAKE   = 0;
	localparam int E1_MAIL   = 1;
	localparam int E1_ACCESS = 2;
	localparam int E1_GENERAL_PIN_THREE  = 3;
	localparam int E1_PS2A   = 4;
	localparam int E1_PS2B   = 5;
	localparam int E1_SCAN   = 6;
	localparam int E1_IBF    = 7;
	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
	} mis_req_t;
	typedef struct packed {
		logic       valid;
		logic       high;
		logic [2:0] index;
		logic [7:0] vector;
	} mis_irq_t;
endpackage

/* File: mis_interrupt_sources.sv */
// interrupt enable, priority and event source logic
`timescale 1ns/100ps

// Notes on behaviour
// - six interrupts, vectors 03H to 2BH
// - per-interrupt enable bit at A8H
// - per-interrupt priority bit at B8H
// - externals level or edge; serial edge
// - unmasked wake event raises wake interrupt
// - fixed polling order within one level
// - enable layout: global D7, wake D5
// - priority layout: wake D5, others D4-D0
// - mask one blocks source, zero passes
// - source registers at 7F00 and 7F02
// - wake pins and rx change latch bits
// - reading 7F00 clears all bits
// - wake pin four both edges
// - ext1 source bit layout
// - ext1 read clears D0, D2-D6 only
// - host input full set/clear
// - scan line high-to-low latches bit
// - general pin three both edges
// - host mailbox write sets bit
// - mailbox bit cleared by mailbox read
module mis_interrupt_sources #(
	parameter int SCAN_LINES = 8
) (
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	input  wire mis_pkg::mis_req_t     sfr_req,
	output logic [7:0]                 sfr_rdata,
	input  wire mis_pkg::mis_req_t     xdata_req,
	output logic [7:0]                 xdata_rdata,
	input  wire logic                  ext0_edge_mode,
	input  wire logic                  ext1_edge_mode,
	input  wire logic                  timer_zero_overflow_flag,
	input  wire logic                  timer_one_overflow_flag,
	input  wire logic                  serial_receive_flag,
	input  wire logic                  serial_transmit_flag,
	input  wire logic                  wake_event_pending,
	input  wire logic                  wake_pin_two,
	input  wire logic                  wake_pin_three,
	input  wire logic                  wake_pin_four,
	input  wire logic                  receive_data_msb,
	input  wire logic                  wake_event_active,
	input  wire logic                  access_bus_request,
	input  wire logic                  general_pin_three,
	input  wire logic [1:0]            ps2_rise,
	input  wire logic [SCAN_LINES-1:0] scan_lines,
	input  wire logic                  mailbox0_host_write,
	input  wire logic                  mailbox0_mcu_read,
	input  wire logic                  host_data_write,
	input  wire logic                  host_data_mcu_read,
	input  wire logic                  irq_ack,
	output mis_pkg::mis_irq_t          irq,
	output logic                       external_request_zero,
	output logic                       external_request_one
);
	logic [7:0]            interrupt_enable, next_enable;
	logic [7:0]            interrupt_priority, next_priority;
	logic [7:0]            ext0_event_source, next_e0_src;
	logic [7:0]            ext0_event_mask, next_e0_mask;
	logic [7:0]            ext1_event_source, next_e1_src;
	logic [7:0]            ext1_event_mask, next_e1_mask;
	logic [7:0]            next_sfr_rdata, next_xdata_rdata;
	logic [3:0]            prev_pins, next_prev_pins;
	logic [SCAN_LINES-1:0] prev_scan, next_prev_scan;
	logic [2:0]            latched, next_latched;
	logic [3:0]            prev_line, next_prev_line;
	logic                  next_req0, next_req1;
	mis_pkg::mis_irq_t     next_irq;
	logic [7:0]            e0_set, e1_set, e0_clr, e1_clr;
	logic [5:0]            line, active;
	logic                  e0_rd, e1_rd;

	//--------------------------------------------------------------
	// register access and event sources
	//--------------------------------------------------------------
	assign e0_rd = xdata_req.rd && xdata_req.addr == mis_pkg::ADDR_EXT0_SRC;
	assign e1_rd = xdata_req.rd && xdata_req.addr == mis_pkg::ADDR_EXT1_SRC;

	always_comb begin
		next_enable      = interrupt_enable;
		next_priority    = interrupt_priority;
		next_e0_mask     = ext0_event_mask;
		next_e1_mask     = ext1_event_mask;
		next_sfr_rdata   = sfr_rdata;
		next_xdata_rdata = xdata_rdata;
		if (sfr_req.wr && sfr_req.addr[7:0] == mis_pkg::ADDR_ENABLE) begin
			next_enable = sfr_req.wdata & mis_pkg::ENABLE_USED;
		end
		if (sfr_req.wr && sfr_req.addr[7:0] == mis_pkg::ADDR_PRIORITY) begin
			next_priority = sfr_req.wdata & mis_pkg::PRIORITY_USED;
		end
		if (xdata_req.wr && xdata_req.addr == mis_pkg::ADDR_EXT0_MASK) begin
			next_e0_mask = xdata_req.wdata;
		end
		if (xdata_req.wr && xdata_req.addr == mis_pkg::ADDR_EXT1_MASK) begin
			next_e1_mask = xdata_req.wdata;
		end
		if (sfr_req.rd) begin
			unique case (sfr_req.addr[7:0])
				mis_pkg::ADDR_ENABLE:   next_sfr_rdata = interrupt_enable;
				mis_pkg::ADDR_PRIORITY: next_sfr_rdata = interrupt_priority;
				default:                next_sfr_rdata = mis_pkg::REG_RESET;
			endcase
		end
		if (xdata_req.rd) begin
			unique case (xdata_req.addr)
				mis_pkg::ADDR_EXT0_SRC:  next_xdata_rdata = ext0_event_source;
				mis_pkg::ADDR_EXT0_MASK: next_xdata_rdata = ext0_event_mask;
				mis_pkg::ADDR_EXT1_SRC:  next_xdata_rdata = ext1_event_source;
				mis_pkg::ADDR_EXT1_MASK: next_xdata_rdata = ext1_event_mask;
				default:                 next_xdata_rdata = mis_pkg::REG_RESET;
			endcase
		end
		next_prev_pins = {receive_data_msb, wake_pin_four, wake_pin_two, wake_pin_three};
		next_prev_scan = scan_lines;
		e0_set = mis_pkg::REG_RESET;
		e0_set[3:0] = next_prev_pins ^ prev_pins;
		e1_set = mis_pkg::REG_RESET;
		e1_set[mis_pkg::E1_WAKE]   = wake_event_active;
		e1_set[mis_pkg::E1_MAIL]   = mailbox0_host_write;
		e1_set[mis_pkg::E1_ACCESS] = access_bus_request;
		e1_set[mis_pkg::E1_GENERAL_PIN_THREE]  = general_pin_three ^ prev_line[2];
		e1_set[mis_pkg::E1_PS2A]   = ps2_rise[0];
		e1_set[mis_pkg::E1_PS2B]   = ps2_rise[1];
		e1_set[mis_pkg::E1_SCAN]   = |(prev_scan & ~scan_lines);
		e1_set[mis_pkg::E1_IBF]    = host_data_write;
		e0_clr = e0_rd ? mis_pkg::EXT0_USED : mis_pkg::REG_RESET;
		// mailbox cleared by its own read
		e1_clr = e1_rd ? mis_pkg::EXT1_RD_CLEAR : mis_pkg::REG_RESET;
		e1_clr[mis_pkg::E1_MAIL] = mailbox0_mcu_read;
		e1_clr[mis_pkg::E1_IBF]  = host_data_mcu_read;
		// set wins over clear
		next_e0_src = (ext0_event_source & ~e0_clr) | e0_set;
		next_e1_src = (ext1_event_source & ~e1_clr) | e1_set;
		next_req0 = |(ext0_event_source & ~ext0_event_mask);
		next_req1 = |(ext1_event_source & ~ext1_event_mask);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			interrupt_enable      <= mis_pkg::REG_RESET;
			interrupt_priority    <= mis_pkg::REG_RESET;
			ext0_event_source     <= mis_pkg::REG_RESET;
			ext0_event_mask       <= mis_pkg::REG_RESET;
			ext1_event_source     <= mis_pkg::REG_RESET;
			ext1_event_mask       <= mis_pkg::REG_RESET;
			sfr_rdata             <= mis_pkg::REG_RESET;
			xdata_rdata           <= mis_pkg::REG_RESET;
			prev_pins             <= '0;
			prev_scan             <= '0;
			external_request_zero <= 1'b0;
			external_request_one  <= 1'b0;
		end else begin
			interrupt_enable      <= next_enable;
			interrupt_priority    <= next_priority;
			ext0_event_source     <= next_e0_src;
			ext0_event_mask       <= next_e0_mask;
			ext1_event_source     <= next_e1_src;
			ext1_event_mask       <= next_e1_mask;
			sfr_rdata             <= next_sfr_rdata;
			xdata_rdata           <= next_xdata_rdata;
			prev_pins             <= next_prev_pins;
			prev_scan             <= next_prev_scan;
			external_request_zero <= next_req0;
			external_request_one  <= next_req1;
		end
	end

	//--------------------------------------------------------------
	// request lines, priority and polling
	//--------------------------------------------------------------
	always_comb begin
		next_prev_line = {serial_receive_flag || serial_transmit_flag, general_pin_three,
			external_request_one, external_request_zero};
		// edge latches for externals and serial
		next_latched = latched;
		if (irq.valid && irq_ack) begin
			unique case (irq.index)
				3'(mis_pkg::IDX_EXT0):   next_latched[0] = 1'b0;
				3'(mis_pkg::IDX_EXT1):   next_latched[1] = 1'b0;
				3'(mis_pkg::IDX_SERIAL): next_latched[2] = 1'b0;
				default:                 next_latched = latched;
			endcase
		end
		if (external_request_zero && !prev_line[0]) begin
			next_latched[0] = 1'b1;
		end
		if (external_request_one && !prev_line[1]) begin
			next_latched[1] = 1'b1;
		end
		if ((serial_receive_flag || serial_transmit_flag) && !prev_line[3]) begin
			next_latched[2] = 1'b1;
		end
		line[mis_pkg::IDX_EXT0]   = ext0_edge_mode ? latched[0] : external_request_zero;
		line[mis_pkg::IDX_TMR0]   = timer_zero_overflow_flag;
		line[mis_pkg::IDX_EXT1]   = ext1_edge_mode ? latched[1] : external_request_one;
		line[mis_pkg::IDX_TMR1]   = timer_one_overflow_flag;
		line[mis_pkg::IDX_SERIAL] = latched[2];
		line[mis_pkg::IDX_WAKE]   = wake_event_pending;
		// gate by own and global enable
		active = line & interrupt_enable[5:0] & {6{interrupt_enable[mis_pkg::BIT_GLOBAL]}};
		next_irq = '0;
		// lowest index wins within a level
		for (int i = mis_pkg::NUM_IRQ - 1; i >= 0; i--) begin
			if (active[i] && !interrupt_priority[i]) begin
				next_irq.valid = 1'b1;
				next_irq.index = 3'(i);
			end
		end
		for (int i = mis_pkg::NUM_IRQ - 1; i >= 0; i--) begin
			if (active[i] && interrupt_priority[i]) begin
				next_irq.valid = 1'b1;
				next_irq.high  = 1'b1;
				next_irq.index = 3'(i);
			end
		end
		next_irq.vector = next_irq.valid ? mis_pkg::VECTORS[next_irq.index] : 8'h00;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			latched   <= '0;
			prev_line <= '0;
			irq       <= '0;
		end else begin
			latched   <= next_latched;
			prev_line <= next_prev_line;
			irq       <= next_irq;
		end
	end

	//--------------------------------------------------------------
	// assertions
	//--------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic [5:0] below_sel;
	assign below_sel = 6'((6'h01 << irq.index) - 6'h01);

	sequence s_w4_edge;
		wake_pin_four != prev_pins[2];
	endsequence
	sequence s_scan_fall;
		|(prev_scan & ~scan_lines);
	endsequence
	sequence s_e0_quiet_read;
		e0_rd && e0_set == 8'h00;
	endsequence

	property p_vector;
		irq.valid |-> irq.vector == mis_pkg::VECTORS[irq.index];
	endproperty
	a_vector: assert property (p_vector) else $error("vector mismatch");
	property p_global;
		!interrupt_enable[mis_pkg::BIT_GLOBAL] |=> !irq.valid;
	endproperty
	a_global: assert property (p_global) else $error("request while disabled");
	property p_level;
		irq.valid && !irq.high |-> $past((active & interrupt_priority[5:0]) == 6'h00);
	endproperty
	a_level: assert property (p_level) else $error("low chosen over high");
	property p_order;
		irq.valid |-> ($past(active) & below_sel
			& (irq.high ? $past(interrupt_priority[5:0]) : ~$past(interrupt_priority[5:0])))
			== 6'h00;
	endproperty
	a_order: assert property (p_order) else $error("polling order broken");
	property p_wake;
		wake_event_pending && interrupt_enable[mis_pkg::IDX_WAKE]
			&& interrupt_enable[mis_pkg::BIT_GLOBAL] |=> irq.valid;
	endproperty
	a_wake: assert property (p_wake) else $error("wake request lost");
	property p_e0_clear;
		s_e0_quiet_read |=> ext0_event_source == 8'h00;
	endproperty
	a_e0_clear: assert property (p_e0_clear) else $error("ext0 read did not clear");
	property p_e1_keep;
		e1_rd && !mailbox0_mcu_read && !host_data_mcu_read
			&& !mailbox0_host_write && !host_data_write |=>
			ext1_event_source[mis_pkg::E1_MAIL] == $past(ext1_event_source[mis_pkg::E1_MAIL])
			&& ext1_event_source[mis_pkg::E1_IBF] == $past(ext1_event_source[mis_pkg::E1_IBF]);
	endproperty
	a_e1_keep: assert property (p_e1_keep) else $error("ext1 read cleared kept bits");
	property p_w4;
		s_w4_edge |=> ext0_event_source[mis_pkg::E0_WAKE4] ##1 external_request_zero
			|| ext0_event_mask[mis_pkg::E0_WAKE4] || $past(e0_rd, 1);
	endproperty
	a_w4: assert property (p_w4) else $error("wake pin four edge missed");
	property p_scan;
		s_scan_fall |=> ext1_event_source[mis_pkg::E1_SCAN];
	endproperty
	a_scan: assert property (p_scan) else $error("scan fall missed");
	property p_ibf;
		host_data_write |=> ext1_event_source[mis_pkg::E1_IBF];
	endproperty
	a_ibf: assert property (p_ibf) else $error("input full not set");
	property p_req;
		(ext1_event_source & ~ext1_event_mask) != 8'h00 |=> external_request_one;
	endproperty
	a_req: assert property (p_req) else $error("ext1 request missing");
endmodule

/* File: mis_core_model.sv */
// core model that takes interrupts offered by the source block
`timescale 1ns/100ps
module mis_core_model (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire mis_pkg::mis_irq_t irq,
	input  wire logic              ack_en,
	output logic                   irq_ack
);
	logic [7:0] taken[$];
	int         lag;

	initial begin
		irq_ack = 1'b0;
		forever begin
			@(posedge mclk);
			#1;
			if (rst_n === 1'b1 && ack_en === 1'b1 && irq.valid === 1'b1) begin
				lag = $urandom_range(2);
				repeat (lag) begin
					@(posedge mclk);
					#1;
				end
				if (irq.valid === 1'b1) begin
					irq_ack = 1'b1;
					taken.push_back(irq.vector);
					@(posedge mclk);
					#1;
					irq_ack = 1'b0;
					// stale selection may linger one cycle
					@(posedge mclk);
				end
			end
		end
	end
endmodule

/* File: tb.sv */
// self-checking testbench for the interrupt source block
`timescale 1ns/100ps
module tb;
	logic              mclk, rst_n, e0m, e1m, t0f, t1f, rxf, txf, wkp, wk2, wk3, wk4, rxm;
	logic              wka, abr, gp3, mbw, mbr, hdw, hdr, ack_en, ack, rz, ro;
	logic [1:0]        ps2;
	logic [7:0]        scan, srd, xrd, q, r, m;
	mis_pkg::mis_req_t sreq, xreq;
	mis_pkg::mis_irq_t irq;
	int                miscompares, compares;

	mis_interrupt_sources #(.SCAN_LINES(8)) i_dut (.mclk(mclk), .rst_n(rst_n),
		.sfr_req(sreq), .sfr_rdata(srd), .xdata_req(xreq), .xdata_rdata(xrd),
		.ext0_edge_mode(e0m), .ext1_edge_mode(e1m), .timer_zero_overflow_flag(t0f),
		.timer_one_overflow_flag(t1f), .serial_receive_flag(rxf), .serial_transmit_flag(txf),
		.wake_event_pending(wkp), .wake_pin_two(wk2), .wake_pin_three(wk3),
		.wake_pin_four(wk4), .receive_data_msb(rxm), .wake_event_active(wka),
		.access_bus_request(abr), .general_pin_three(gp3), .ps2_rise(ps2), .scan_lines(scan),
		.mailbox0_host_write(mbw), .mailbox0_mcu_read(mbr), .host_data_write(hdw),
		.host_data_mcu_read(hdr), .irq_ack(ack), .irq(irq), .external_request_zero(rz),
		.external_request_one(ro));
	mis_core_model i_core (.mclk(mclk), .rst_n(rst_n), .irq(irq), .ack_en(ack_en), .irq_ack(ack));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic acc(input bit x, input logic [15:0] a, input logic w, input logic [7:0] d);
		mis_pkg::mis_req_t t;
		t = '{addr: a, wr: w, rd: !w, wdata: d};
		@(posedge mclk);
		if (x) xreq <= t;
		else sreq <= t;
		@(posedge mclk);
		xreq <= '0;
		sreq <= '0;
		#1;
		q = x ? xrd : srd;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [7:0] order_vec(input int p, input int k);
		int o[3];
		if (p != 0) begin
			o = '{mis_pkg::IDX_SERIAL, mis_pkg::IDX_EXT0, mis_pkg::IDX_EXT1};
		end else begin
			o = '{mis_pkg::IDX_EXT0, mis_pkg::IDX_EXT1, mis_pkg::IDX_SERIAL};
		end
		return mis_pkg::VECTORS[o[k]];
	endfunction

	task automatic print_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		#400000;
		miscompares++;
		print_verdict();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{sreq, xreq, e0m, e1m, t0f, t1f, rxf, txf, wkp, wk2, wk3, wk4, rxm} = '0;
		{wka, abr, gp3, ps2, mbw, mbr, hdw, hdr, ack_en} = '0;
		scan = 8'hFF;
		rst_n = 1'b0;
		void'($urandom(32'h085B));
		cyc(3);
		rst_n <= 1'b1;
		acc(0, 16'h00A8, 0, 8'h00); chk(q, 8'h00, "enable reset");
		acc(0, 16'h00B8, 0, 8'h00); chk(q, 8'h00, "priority reset");
		for (int i = 0; i < 5; i++) begin
			acc(1, 16'h7F00 + 16'(i), 0, 8'h00); chk(q, 8'h00, "xdata reset");
		end
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			r = 8'($urandom);
			m = 8'($urandom);
			if (i == 0) m = 8'h0F;
			if (i < 2) r = 8'hFF;
			acc(0, 16'h00A8, 1, r); acc(0, 16'h00A8, 0, 8'h00);
			chk(q, r & mis_pkg::ENABLE_USED, "enable");
			acc(0, 16'h00B8, 1, r); acc(0, 16'h00B8, 0, 8'h00);
			chk(q, r & mis_pkg::PRIORITY_USED, "priority");
			acc(1, mis_pkg::ADDR_EXT0_MASK, 1, m);
			cyc(1);
			wk3 <= wk3 ^ r[0];
			wk2 <= wk2 ^ r[1];
			wk4 <= wk4 ^ r[2];
			rxm <= rxm ^ r[3];
			cyc(4);
			#1;
			chk({7'h00, rz}, {7'h00, |(r[3:0] & ~m[3:0])}, "request zero");
			acc(1, mis_pkg::ADDR_EXT0_SRC, 0, 8'h00); chk(q, {4'h0, r[3:0]}, "ext0 src");
			acc(1, mis_pkg::ADDR_EXT0_SRC, 0, 8'h00); chk(q, 8'h00, "ext0 clear");
		end
		acc(0, 16'h00A8, 1, 8'h00);
		acc(1, mis_pkg::ADDR_EXT0_MASK, 1, 8'h00);
		$display("test ext0 done");
		cyc(1);
		{hdw, mbw, abr, wka, ps2, scan, gp3} <= {4'hF, 2'h3, 8'hFE, ~gp3};
		cyc(1);
		{hdw, mbw, abr, wka, ps2} <= '0;
		cyc(4);
		#1;
		chk({7'h00, ro}, 8'h01, "request one");
		acc(1, mis_pkg::ADDR_EXT1_SRC, 0, 8'h00); chk(q, 8'hFF, "ext1 src");
		acc(1, mis_pkg::ADDR_EXT1_SRC, 0, 8'h00); chk(q, 8'h82, "ext1 read");
		scan <= 8'hFF;
		hdr <= 1'b1;
		cyc(1);
		hdr <= 1'b0;
		acc(1, mis_pkg::ADDR_EXT1_SRC, 0, 8'h00); chk(q, 8'h02, "data read");
		mbr <= 1'b1;
		cyc(1);
		mbr <= 1'b0;
		acc(1, mis_pkg::ADDR_EXT1_SRC, 0, 8'h00); chk(q, 8'h00, "mailbox read");
		$display("test ext1 done");
		for (int p = 0; p < 2; p++) begin
			acc(0, 16'h00B8, 1, p ? 8'h10 : 8'h00);
			acc(0, 16'h00A8, 1, 8'h15);
			cyc(1);
			{e0m, e1m, rxf, wk2, gp3} <= {3'h7, ~wk2, ~gp3};
			cyc(6);
			#1;
			chk({7'h00, irq.valid}, 8'h00, "global off");
			ack_en <= 1'b1;
			acc(0, 16'h00A8, 1, 8'h95);
			cyc(30);
			chk(8'(i_core.taken.size()), 8'h03, "taken count");
			for (int k = 0; k < 3; k++) begin
				chk(i_core.taken[k], order_vec(p, k), "poll order");
			end
			ack_en <= 1'b0;
			rxf <= 1'b0;
			acc(1, mis_pkg::ADDR_EXT0_SRC, 0, 8'h00);
			acc(1, mis_pkg::ADDR_EXT1_SRC, 0, 8'h00);
			acc(0, 16'h00A8, 1, 8'h00);
			i_core.taken.delete();
		end
		$display("test order done");
		wkp <= 1'b1;
		acc(0, 16'h00B8, 1, 8'h20);
		acc(0, 16'h00A8, 1, 8'hA0);
		cyc(3);
		#1;
		chk({irq.valid, irq.high, 3'h0, irq.index}, 8'hC5, "wake select");
		chk(irq.vector, 8'h2B, "wake vector");
		$display("test wake done");
		{t0f, t1f, e0m, wk3} <= {2'h3, 1'b0, ~wk3};
		acc(0, 16'h00B8, 1, 8'h00);
		acc(0, 16'h00A8, 1, 8'h8B);
		cyc(3);
		#1;
		chk(irq.vector, 8'h03, "level ext0 first");
		acc(1, mis_pkg::ADDR_EXT0_SRC, 0, 8'h00);
		cyc(2);
		#1;
		chk(irq.vector, 8'h0B, "timer zero next");
		t0f <= 1'b0;
		cyc(2);
		#1;
		chk(irq.vector, 8'h1B, "timer one last");
		t1f <= 1'b0;
		$display("test level done");
		print_verdict();
	end
endmodule
